// *** pbsd_pkg.sv ***
// shared widths, encodings and carriers for the burst sram cycle decode
package pbsd_pkg;

  // word layout: two lanes of eight data bits plus one parity bit each
  localparam int ADDR_W = 18;
  localparam int LANE_W = 9;
  localparam int LANE_N = 2;
  localparam int DATA_W = LANE_W * LANE_N;

  // burst counter steps the two lowest address bits
  localparam int BURST_W = 2;

  // sleep entry and exit each take this many clock cycles
  localparam int SLEEP_CYCLES = 2;
  localparam int SLEEP_CNT_W = 2;
  localparam logic [SLEEP_CNT_W-1:0] SLEEP_CNT_LAST = SLEEP_CNT_W'(SLEEP_CYCLES - 1);
  localparam logic [SLEEP_CNT_W-1:0] SLEEP_CNT_RST = 2'h0;

  // reset values and the burst counter step
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
  localparam logic [LANE_N-1:0] LANES_OFF = 2'h0;
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

  // operation held in a pipeline stage
  typedef enum logic [2:0]
  {
    OP_IDLE = 3'b000,
    OP_READ = 3'b001,
    OP_WRITE = 3'b010,
    OP_ABORT = 3'b011
  } pbsd_op_t;

  // kind of burst latched at its first beat
  typedef enum logic [1:0]
  {
    BURST_NONE = 2'b00,
    BURST_READ = 2'b01,
    BURST_WRITE = 2'b10
  } pbsd_burst_t;

  // sleep sequencer states
  typedef enum logic [1:0]
  {
    SLP_AWAKE = 2'b00,
    SLP_ENTER = 2'b01,
    SLP_ASLEEP = 2'b10,
    SLP_EXIT = 2'b11
  } pbsd_sleep_t;

  // synchronous control pins sampled at each rising edge
  typedef struct packed {
    logic clock_hold_n;
    logic chip_sel_one_n;
    logic chip_sel_two;
    logic chip_sel_three_n;
    logic advance_load;
    logic write_request_n;
    logic [LANE_N-1:0] lane_write_sel_n;
  } pbsd_ctrl_t;

  // one registered access in the pipeline
  typedef struct packed {
    pbsd_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [LANE_N-1:0] lanes;
  } pbsd_stage_t;

  localparam pbsd_stage_t STAGE_IDLE = pbsd_stage_t'{OP_IDLE, ADDR_RST, LANES_OFF};

endpackage : pbsd_pkg

// *** pbsd_burst_counter.sv ***
// two-bit burst address sequencer, linear or interleaved
`timescale 1ns/1ns
module pbsd_burst_counter
  import pbsd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic advance,
  input wire logic [BURST_W-1:0] start_low,
  input wire logic interleave,
  output logic [BURST_W-1:0] next_low
);

  logic [BURST_W-1:0] base_reg;
  logic [BURST_W-1:0] base_next;
  logic [BURST_W-1:0] cnt_reg;
  logic [BURST_W-1:0] cnt_next;
  logic [BURST_W-1:0] step_cnt;

  // load restarts the sequence, advance moves one beat on, wrapping after four
  always_comb
  begin
    base_next = base_reg;
    cnt_next = cnt_reg;
    if (load)
    begin
      base_next = start_low;
      cnt_next = BURST_RST;
    end
    else if (advance)
    begin
      cnt_next = cnt_reg + BURST_STEP;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      base_reg <= BURST_RST;
      cnt_reg <= BURST_RST;
    end
    else
    begin
      base_reg <= base_next;
      cnt_reg <= cnt_next;
    end
  end

  // address of the following beat: sum for linear, exclusive-or for interleaved
  always_comb
  begin
    step_cnt = cnt_reg + BURST_STEP;
    next_low = interleave ? (base_reg ^ step_cnt) : (base_reg + step_cnt);
  end

endmodule : pbsd_burst_counter

// *** pbsd_cycle_decode.sv ***
// synchronous cycle decode of a pipelined common-io burst sram
//
// Overview of operation
// - inactive select with load starts deselect; advance continues
// - all selects, load, no write begins read
// - advance during read burst reads next address
// - read begun with drive off stays tri-stated
// - dummy continuation advances address, bus tri-stated
// - selects, load, write, some lane starts write
// - advance in write burst writes next address
// - write start with no lanes is abort
// - continuation with no lanes advances, writes nothing
// - clock hold high ignores the edge entirely
// - lanes decoded from write request and selects
// - any write cycle tri-states all data lanes
// - drive enable acts unclocked, masked during writes
// - read data driven only while drive enabled
// - reset leaves device deselected, bus tri-stated
// - burst counter wraps four, linear or interleaved
// - read data appears one edge after address
// - sleep overrides all, two cycles in and out
`timescale 1ns/1ns
module pbsd_cycle_decode
  import pbsd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire pbsd_ctrl_t ctrl,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic burst_order,
  input wire logic sleep_request,
  input wire logic output_drive_en_n,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic core_rd_en,
  output logic [ADDR_W-1:0] core_rd_addr,
  input wire logic [DATA_W-1:0] core_rd_data,
  output logic [LANE_N-1:0] core_wr_en,
  output logic [ADDR_W-1:0] core_wr_addr,
  output logic [DATA_W-1:0] core_wr_data,
  output pbsd_op_t cycle_op,
  output logic sleep_active
);

  // asynchronous pin synchronisers
  logic sleep_sync1_reg;
  logic sleep_sync1_next;
  logic sleep_sync2_reg;
  logic sleep_sync2_next;
  logic order_sync1_reg;
  logic order_sync1_next;
  logic order_sync2_reg;
  logic order_sync2_next;

  // sleep sequencer
  pbsd_sleep_t sleep_state_reg;
  pbsd_sleep_t sleep_state_next;
  logic [SLEEP_CNT_W-1:0] sleep_cnt_reg;
  logic [SLEEP_CNT_W-1:0] sleep_cnt_next;
  logic sleep_active_reg;
  logic sleep_active_next;

  // access pipeline
  pbsd_burst_t burst_kind_reg;
  pbsd_burst_t burst_kind_next;
  pbsd_stage_t stage1_reg;
  pbsd_stage_t stage1_next;
  pbsd_stage_t stage2_reg;
  pbsd_stage_t stage2_next;
  logic read_drive_reg;
  logic read_drive_next;
  logic [DATA_W-1:0] dq_out_reg;
  logic [DATA_W-1:0] dq_out_next;
  logic rd_en_reg;
  logic rd_en_next;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic [ADDR_W-1:0] rd_addr_next;
  logic [LANE_N-1:0] wr_en_reg;
  logic [LANE_N-1:0] wr_en_next;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [ADDR_W-1:0] wr_addr_next;
  logic [DATA_W-1:0] wr_data_reg;
  logic [DATA_W-1:0] wr_data_next;

  // decode terms
  logic awake;
  logic edge_live;
  logic all_sel;
  logic any_lane;
  logic cnt_load;
  logic cnt_adv;
  logic [BURST_W-1:0] burst_next_low;
  logic [ADDR_W-1:0] burst_addr;
  logic [LANE_N-1:0] lane_sel_n;

  // sleep and mode pins pass two flip-flops before any use
  always_comb
  begin
    sleep_sync1_next = sleep_request;
    sleep_sync2_next = sleep_sync1_reg;
    order_sync1_next = burst_order;
    order_sync2_next = order_sync1_reg;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sleep_sync1_reg <= 1'b0;
      sleep_sync2_reg <= 1'b0;
      order_sync1_reg <= 1'b0;
      order_sync2_reg <= 1'b0;
    end
    else
    begin
      sleep_sync1_reg <= sleep_sync1_next;
      sleep_sync2_reg <= sleep_sync2_next;
      order_sync1_reg <= order_sync1_next;
      order_sync2_reg <= order_sync2_next;
    end
  end

  // sleep entry and exit, each spending a fixed number of cycles
  always_comb
  begin
    sleep_state_next = sleep_state_reg;
    sleep_cnt_next = sleep_cnt_reg;
    case (sleep_state_reg)
      SLP_AWAKE:
      begin
        if (sleep_sync2_reg)
        begin
          sleep_state_next = SLP_ENTER;
          sleep_cnt_next = SLEEP_CNT_RST;
        end
      end
      SLP_ENTER:
      begin
        if (sleep_cnt_reg == SLEEP_CNT_LAST)
        begin
          sleep_state_next = SLP_ASLEEP;
          sleep_cnt_next = SLEEP_CNT_RST;
        end
        else
        begin
          sleep_cnt_next = sleep_cnt_reg + 2'h1;
        end
      end
      SLP_ASLEEP:
      begin
        if (!sleep_sync2_reg)
        begin
          sleep_state_next = SLP_EXIT;
          sleep_cnt_next = SLEEP_CNT_RST;
        end
      end
      SLP_EXIT:
      begin
        if (sleep_cnt_reg == SLEEP_CNT_LAST)
        begin
          sleep_state_next = SLP_AWAKE;
          sleep_cnt_next = SLEEP_CNT_RST;
        end
        else
        begin
          sleep_cnt_next = sleep_cnt_reg + 2'h1;
        end
      end
      default:
      begin
        sleep_state_next = SLP_AWAKE;
        sleep_cnt_next = SLEEP_CNT_RST;
      end
    endcase
    sleep_active_next = (sleep_state_next != SLP_AWAKE);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sleep_state_reg <= SLP_AWAKE;
      sleep_cnt_reg <= SLEEP_CNT_RST;
      sleep_active_reg <= 1'b0;
    end
    else
    begin
      sleep_state_reg <= sleep_state_next;
      sleep_cnt_reg <= sleep_cnt_next;
      sleep_active_reg <= sleep_active_next;
    end
  end

  // decode terms for the current edge
  assign awake = (sleep_state_reg == SLP_AWAKE);
  assign edge_live = awake && !ctrl.clock_hold_n;
  assign all_sel = !ctrl.chip_sel_one_n && ctrl.chip_sel_two && !ctrl.chip_sel_three_n;
  assign lane_sel_n = ctrl.lane_write_sel_n;
  assign any_lane = !(&lane_sel_n);
  assign burst_addr = {stage1_reg.addr[ADDR_W-1:BURST_W], burst_next_low};

  pbsd_burst_counter u_burst
  (
    .clk(clk),
    .rst(rst),
    .load(cnt_load),
    .advance(cnt_adv),
    .start_low(addr[BURST_W-1:0]),
    .interleave(order_sync2_reg),
    .next_low(burst_next_low)
  );

  // cycle decode, read output stage and late write stage
  always_comb
  begin
    burst_kind_next = burst_kind_reg;
    stage1_next = stage1_reg;
    stage2_next = stage2_reg;
    read_drive_next = read_drive_reg;
    dq_out_next = dq_out_reg;
    rd_en_next = 1'b0;
    rd_addr_next = rd_addr_reg;
    wr_en_next = LANES_OFF;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    cnt_load = 1'b0;
    cnt_adv = 1'b0;
    if (!awake)
    begin
      // pending accesses are dropped while sleeping
      burst_kind_next = BURST_NONE;
      stage1_next = STAGE_IDLE;
      stage2_next = STAGE_IDLE;
      read_drive_next = 1'b0;
    end
    else if (edge_live)
    begin
      // data of the access registered on the previous edge goes out now
      read_drive_next = (stage1_reg.op == OP_READ);
      if (stage1_reg.op == OP_READ)
      begin
        dq_out_next = core_rd_data;
      end
      // write data is taken on the second edge after its address
      stage2_next = stage1_reg;
      if (stage2_reg.op == OP_WRITE)
      begin
        wr_en_next = stage2_reg.lanes;
        wr_addr_next = stage2_reg.addr;
        wr_data_next = dq_in;
      end
      if (!ctrl.advance_load)
      begin
        stage1_next.lanes = LANES_OFF;
        if (!all_sel)
        begin
          burst_kind_next = BURST_NONE;
          stage1_next.op = OP_IDLE;
        end
        else if (ctrl.write_request_n)
        begin
          burst_kind_next = BURST_READ;
          stage1_next.op = OP_READ;
          stage1_next.addr = addr;
          rd_en_next = 1'b1;
          rd_addr_next = addr;
          cnt_load = 1'b1;
        end
        else
        begin
          // a write with no lane selected is kept as an abort beat
          burst_kind_next = BURST_WRITE;
          stage1_next.op = any_lane ? OP_WRITE : OP_ABORT;
          stage1_next.addr = addr;
          stage1_next.lanes = ~lane_sel_n;
          cnt_load = 1'b1;
        end
      end
      else
      begin
        case (burst_kind_reg)
          BURST_READ:
          begin
            stage1_next.op = OP_READ;
            stage1_next.addr = burst_addr;
            stage1_next.lanes = LANES_OFF;
            rd_en_next = 1'b1;
            rd_addr_next = burst_addr;
            cnt_adv = 1'b1;
          end
          BURST_WRITE:
          begin
            stage1_next.op = any_lane ? OP_WRITE : OP_ABORT;
            stage1_next.addr = burst_addr;
            stage1_next.lanes = ~lane_sel_n;
            cnt_adv = 1'b1;
          end
          default:
          begin
            stage1_next.op = OP_IDLE;
            stage1_next.lanes = LANES_OFF;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      burst_kind_reg <= BURST_NONE;
      stage1_reg <= STAGE_IDLE;
      stage2_reg <= STAGE_IDLE;
      read_drive_reg <= 1'b0;
      dq_out_reg <= DATA_RST;
      rd_en_reg <= 1'b0;
      rd_addr_reg <= ADDR_RST;
      wr_en_reg <= LANES_OFF;
      wr_addr_reg <= ADDR_RST;
      wr_data_reg <= DATA_RST;
    end
    else
    begin
      burst_kind_reg <= burst_kind_next;
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
      read_drive_reg <= read_drive_next;
      dq_out_reg <= dq_out_next;
      rd_en_reg <= rd_en_next;
      rd_addr_reg <= rd_addr_next;
      wr_en_reg <= wr_en_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
    end
  end

  // drive enable gates the registered read state without a clock
  assign dq_oe = read_drive_reg && !output_drive_en_n;
  assign dq_out = dq_out_reg;
  assign core_rd_en = rd_en_reg;
  assign core_rd_addr = rd_addr_reg;
  assign core_wr_en = wr_en_reg;
  assign core_wr_addr = wr_addr_reg;
  assign core_wr_data = wr_data_reg;
  assign cycle_op = stage1_reg.op;
  assign sleep_active = sleep_active_reg;

  // checks on the decode
  desel_bus_a: assert property (@(posedge clk) disable iff (rst)
    edge_live && !ctrl.advance_load && !all_sel |=> ##1 !dq_oe)
    else $error("deselect did not tri-state the bus");

  read_addr_a: assert property (@(posedge clk) disable iff (rst)
    edge_live && !ctrl.advance_load && all_sel && ctrl.write_request_n
    |=> rd_en_reg && rd_addr_reg == $past(addr) && stage1_reg.op == OP_READ)
    else $error("read begin did not use the external address");

  read_cont_a: assert property (@(posedge clk) disable iff (rst)
    edge_live && ctrl.advance_load && burst_kind_reg == BURST_READ
    |=> rd_en_reg && burst_kind_reg == BURST_READ)
    else $error("read burst did not continue");

  dummy_read_a: assert property (@(posedge clk) disable iff (rst)
    edge_live && !ctrl.advance_load && all_sel && ctrl.write_request_n && output_drive_en_n
    |=> core_rd_en && core_rd_addr == $past(addr))
    else $error("dummy read skipped the core access");

  lane_decode_a: assert property (@(posedge clk) disable iff (rst)
    edge_live && !ctrl.advance_load && all_sel && !ctrl.write_request_n
    |=> stage1_reg.lanes == ~$past(lane_sel_n))
    else $error("lane selects decoded wrongly");

  write_late_a: assert property (@(posedge clk) disable iff (rst)
    edge_live && stage2_reg.op == OP_WRITE
    |=> core_wr_en == $past(stage2_reg.lanes) && core_wr_data == $past(dq_in))
    else $error("write beat not taken on the second edge");

  abort_quiet_a: assert property (@(posedge clk) disable iff (rst)
    stage2_reg.op != OP_WRITE |=> core_wr_en == LANES_OFF)
    else $error("aborted beat wrote the core");

  stall_hold_a: assert property (@(posedge clk) disable iff (rst)
    awake && ctrl.clock_hold_n
    |=> stage1_reg == $past(stage1_reg) && burst_kind_reg == $past(burst_kind_reg)
        && !core_rd_en && core_wr_en == LANES_OFF)
    else $error("held edge changed the operation");

  write_tri_a: assert property (@(posedge clk) disable iff (rst)
    edge_live && (stage1_reg.op == OP_WRITE || stage1_reg.op == OP_ABORT) |=> !dq_oe)
    else $error("bus driven during a write cycle");

  read_pipe_a: assert property (@(posedge clk) disable iff (rst)
    edge_live && stage1_reg.op == OP_READ
    |=> read_drive_reg && dq_out == $past(core_rd_data))
    else $error("read data not presented one edge later");

  reset_idle_a: assert property (@(posedge clk)
    $past(rst) && !rst |-> !dq_oe && burst_kind_reg == BURST_NONE && !sleep_active)
    else $error("not deselected after reset");

  sleep_enter_a: assert property (@(posedge clk) disable iff (rst)
    sleep_state_reg == SLP_AWAKE && sleep_sync2_reg
    |=> sleep_state_reg == SLP_ENTER ##1 sleep_state_reg == SLP_ENTER
        ##1 sleep_state_reg == SLP_ASLEEP && !dq_oe)
    else $error("sleep entry not two cycles");

endmodule : pbsd_cycle_decode

// *** pbsd_far_model.sv ***
// far-side model: common data bus resolution and a small storage core
`timescale 1ns/1ns
module pbsd_far_model
  import pbsd_pkg::*;
(
  input wire logic clk,
  input wire logic drive,
  input wire logic [DATA_W-1:0] drive_data,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe,
  output logic [DATA_W-1:0] dq_in,
  input wire logic [ADDR_W-1:0] core_rd_addr,
  output logic [DATA_W-1:0] core_rd_data,
  input wire logic [LANE_N-1:0] core_wr_en,
  input wire logic [ADDR_W-1:0] core_wr_addr,
  input wire logic [DATA_W-1:0] core_wr_data
);
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] last_reg;

  // core starts with a known pattern so reads are predictable
  initial
  begin
    for (int i = 0; i < 16; i++)
    begin
      mem[i] = 18'h2a000 | 18'(i);
    end
    last_reg = 18'h00000;
  end

  // wire level: controller data, else device data, else a floating bus
  always_comb
  begin
    if (drive)
      dq_in = drive_data;
    else if (dq_oe)
      dq_in = dq_out;
    else
      dq_in = ~last_reg; // no pull: never shows the stale value
  end

  always @(posedge clk)
  begin
    last_reg <= dq_in;
  end

  // core answers combinationally and writes only the enabled lanes
  assign core_rd_data = mem[core_rd_addr[3:0]];

  always @(posedge clk)
  begin
    if (core_wr_en[0])
      mem[core_wr_addr[3:0]][8:0] <= core_wr_data[8:0];
    if (core_wr_en[1])
      mem[core_wr_addr[3:0]][17:9] <= core_wr_data[17:9];
  end
endmodule : pbsd_far_model

// *** pipelined_burst_sram_cycle_decode_tb.sv ***
// self-checking bench for the burst sram cycle decode
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module pipelined_burst_sram_cycle_decode_tb;
  import pbsd_pkg::*;
  localparam logic [2:0] SEL_ON = 3'h2;
  localparam logic [2:0] SEL_OFF = 3'h5;
  logic clk, rst, burst_order, sleep_request, oe_n, drive;
  pbsd_ctrl_t ctrl;
  logic [ADDR_W-1:0] addr, core_rd_addr, core_wr_addr;
  logic [DATA_W-1:0] dq_in, dq_out, core_rd_data, core_wr_data, drive_data;
  logic [DATA_W-1:0] shadow [16];
  logic [LANE_N-1:0] core_wr_en;
  logic dq_oe, core_rd_en, sleep_active;
  pbsd_op_t cycle_op;
  int n_mismatch = 0;
  int num_checks = 0;

  pbsd_cycle_decode u_dut (.clk(clk), .rst(rst), .ctrl(ctrl), .addr(addr),
    .burst_order(burst_order), .sleep_request(sleep_request), .output_drive_en_n(oe_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .core_rd_en(core_rd_en),
    .core_rd_addr(core_rd_addr), .core_rd_data(core_rd_data), .core_wr_en(core_wr_en),
    .core_wr_addr(core_wr_addr), .core_wr_data(core_wr_data), .cycle_op(cycle_op),
    .sleep_active(sleep_active));

  pbsd_far_model u_far (.clk(clk), .drive(drive), .drive_data(drive_data), .dq_out(dq_out),
    .dq_oe(dq_oe), .dq_in(dq_in), .core_rd_addr(core_rd_addr), .core_rd_data(core_rd_data),
    .core_wr_en(core_wr_en), .core_wr_addr(core_wr_addr), .core_wr_data(core_wr_data));

  // 20 mhz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // one sampled edge with the given pins, returning 5 ns after it
  task automatic op(input logic [2:0] sel, input logic adv, input logic wr_n,
    input logic [1:0] ln, input logic [17:0] a);
    begin
      ctrl = '{1'b0, sel[2], sel[1], sel[0], adv, wr_n, ln};
      addr = a;
      @(posedge clk);
      #5;
    end
  endtask : op

  task automatic idle();
    begin
      op(SEL_OFF, 1'b0, 1'b1, 2'h3, 18'h00000);
    end
  endtask : idle

  task automatic rd1(input logic [17:0] a, input logic oen);
    begin
      oe_n = oen;
      op(SEL_ON, 1'b0, 1'b1, 2'h0, a);
      `CHK(core_rd_en, 1'b1)
      `CHK(core_rd_addr, a)
      `CHK(cycle_op, OP_READ)
      idle();
      `CHK(dq_out, shadow[a[3:0]])
      `CHK(dq_oe, !oen)
    end
  endtask : rd1

  // single write; lanes low select, both high aborts
  task automatic wr1(input logic [17:0] a, input logic [1:0] ln, input logic [17:0] d);
    begin
      oe_n = 1'b0;
      op(SEL_ON, 1'b0, 1'b0, ln, a);
      `CHK(cycle_op, (ln == 2'h3) ? OP_ABORT : OP_WRITE)
      idle();
      `CHK(dq_oe, 1'b0)
      drive_data = d;
      drive = 1'b1;
      idle();
      `CHK(core_wr_en, ~ln)
      if (ln != 2'h3)
      begin
        `CHK(core_wr_addr, a)
        `CHK(core_wr_data, d)
      end
      drive = 1'b0;
      if (!ln[0])
        shadow[a[3:0]][8:0] = d[8:0];
      if (!ln[1])
        shadow[a[3:0]][17:9] = d[17:9];
    end
  endtask : wr1

  // write burst with an aborted middle beat
  task automatic wburst();
    begin
      op(SEL_ON, 1'b0, 1'b0, 2'h0, 18'h0000c);
      op(SEL_OFF, 1'b1, 1'b1, 2'h3, 18'h3ffff);
      `CHK(cycle_op, OP_ABORT)
      drive_data = 18'h15a5a;
      drive = 1'b1;
      op(SEL_OFF, 1'b1, 1'b1, 2'h0, 18'h3ffff);
      `CHK(core_wr_en, 2'h3)
      `CHK(core_wr_addr, 18'h0000c)
      drive_data = 18'h00bad;
      idle();
      `CHK(core_wr_en, 2'h0)
      drive_data = 18'h2c3c3;
      idle();
      `CHK(core_wr_en, 2'h3)
      `CHK(core_wr_addr, 18'h0000e)
      `CHK(core_wr_data, 18'h2c3c3)
      drive = 1'b0;
      shadow[12] = 18'h15a5a;
      shadow[14] = 18'h2c3c3;
      rd1(18'h0000e, 1'b0);
    end
  endtask : wburst

  // read burst, selects and write request junk on continuation beats
  task automatic burst(input logic mode);
    logic [17:0] b;
    logic [1:0] lo;
    begin
      b = 18'h00015;
      burst_order = mode;
      repeat (3) idle();
      oe_n = 1'b0;
      op(SEL_ON, 1'b0, 1'b1, 2'h3, b);
      for (int k = 1; k < 4; k++)
      begin
        lo = mode ? (b[1:0] ^ 2'(k)) : (b[1:0] + 2'(k));
        oe_n = k[0];
        op(SEL_OFF, 1'b1, 1'b0, 2'h0, 18'h3ffff);
        `CHK(core_rd_addr, {b[17:2], lo})
        `CHK(dq_oe, !oe_n)
      end
      idle();
      `CHK(dq_out, shadow[{b[3:2], lo}])
    end
  endtask : burst

  task automatic desel();
    logic [2:0] pat [3];
    begin
      pat = '{3'h6, 3'h0, 3'h3};
      oe_n = 1'b0;
      foreach (pat[i])
      begin
        op(pat[i], 1'b0, 1'b1, 2'h3, 18'h00001);
        op(SEL_ON, 1'b1, 1'b1, 2'h3, 18'h00001);
        `CHK(core_rd_en, 1'b0)
        `CHK(cycle_op, OP_IDLE)
        `CHK(dq_oe, 1'b0)
      end
    end
  endtask : desel

  task automatic stall();
    begin
      oe_n = 1'b0;
      op(SEL_ON, 1'b0, 1'b1, 2'h3, 18'h00006);
      ctrl.clock_hold_n = 1'b1;
      ctrl.write_request_n = 1'b0;
      repeat (3)
      begin
        @(posedge clk);
        #5;
        `CHK(core_rd_en, 1'b0)
        `CHK(cycle_op, OP_READ)
        `CHK(core_rd_addr, 18'h00006)
      end
      idle();
      `CHK(dq_out, shadow[6])
    end
  endtask : stall

  task automatic wait_sleep(input logic v);
    int n;
    begin
      n = 0;
      while (sleep_active !== v && n < 8)
      begin
        idle();
        n++;
      end
      `CHK(sleep_active, v)
    end
  endtask : wait_sleep

  task automatic sleep();
    begin
      sleep_request = 1'b1;
      wait_sleep(1'b1);
      oe_n = 1'b0;
      repeat (3) op(SEL_ON, 1'b0, 1'b1, 2'h3, 18'h00003);
      `CHK(core_rd_en, 1'b0)
      `CHK(dq_oe, 1'b0)
      sleep_request = 1'b0;
      wait_sleep(1'b0);
      repeat (3) idle();
      rd1(18'h00003, 1'b0);
    end
  endtask : sleep

  task automatic summarize();
    begin
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask : summarize

  // watchdog well past the expected run of about ninety cycles
  initial
  begin
    #(3000 * 50);
    n_mismatch++;
    summarize();
  end

  // main sequence
  initial
  begin
    for (int i = 0; i < 16; i++)
    begin
      shadow[i] = 18'h2a000 | 18'(i);
    end
    rst = 1'b1;
    ctrl = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 2'h3};
    addr = 18'h00000;
    burst_order = 1'b0;
    sleep_request = 1'b0;
    oe_n = 1'b0;
    drive = 1'b0;
    drive_data = 18'h00000;
    repeat (16) @(posedge clk);
    #5;
    rst = 1'b0;
    `CHK(dq_oe, 1'b0)
    `CHK(cycle_op, OP_IDLE)
    idle();
    for (int i = 0; i < 4; i++)
    begin
      wr1(18'h00008 + 18'(i), 2'(i), 18'h1b0f0 + 18'(i));
      rd1(18'h00008 + 18'(i), 1'b0);
    end
    rd1(18'h00009, 1'b1);
    wburst();
    burst(1'b0);
    burst(1'b1);
    desel();
    stall();
    sleep();
    summarize();
  end
endmodule : pipelined_burst_sram_cycle_decode_tb
